// ===== design/sea_collector.sv
// Alarm collector and owner logic facing one memory support instance
`timescale 1ns/1ps
`include "sea_defs.svh"
module sea_collector #(
   parameter int PERIOD_W = 16
) (
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // Software port
   input  wire sea_pkg::sea_addr_t  sw_addr,
   input  wire sea_pkg::sea_word_t  sw_wdata,
   input  wire logic                sw_wr,
   input  wire logic                sw_rd,
   output sea_pkg::sea_word_t       sw_rdata,
   output logic                     irq,
   output logic                     owner_halt,
   // Link
   sea_link_if.collector            link
);
   import sea_pkg::*;
   initial begin
      if (PERIOD_W < 1 || PERIOD_W > 32) $error("PERIOD_W out of range");
   end
   typedef enum logic [1:0] {SEA_IDLE, SEA_RD, SEA_WAIT, SEA_SPUR} sea_state_e;

   ////////////////////////////////////////////////////////////////////////////
   sea_state_e            st, next_st;
   logic [`SEA_EV_W-1:0]  status, next_status, enable, next_enable;
   logic [3:0]            addr, next_addr;
   logic [31:0]           wdata, next_wdata, rdat, next_rdat, swr, next_swr;
   logic [PERIOD_W-1:0]   period, next_period, tmr, next_tmr;
   logic                  halt, next_halt, spur_req, next_spur_req;
   logic                  l_rd, l_wr;
   logic [3:0]            l_addr;
   logic [31:0]           l_wdata;
   logic [`SEA_EV_W-1:0]  ev, clr;

   always_comb begin
      ev = '0;
      ev[`SEA_EV_ALARM]  = link.alarm_corr | link.alarm_uncorr | link.alarm_addr;
      ev[`SEA_EV_NOTIFY] = link.owner_notify;
      ev[`SEA_EV_DONE]   = st == SEA_WAIT;
      ev[`SEA_EV_SPURIOUS] = st == SEA_WAIT && spur_req && link.reg_rdata != `SEA_ZERO32;
      clr = (sw_wr && sw_addr == `SEA_CREG_CLEAR) ? sw_wdata[`SEA_EV_W-1:0] : '0;
      next_status = (status & ~clr) | ev;
      next_enable = (sw_wr && sw_addr == `SEA_CREG_ENABLE) ? sw_wdata[`SEA_EV_W-1:0] : enable;
      next_addr   = (sw_wr && sw_addr == `SEA_CREG_ADDR) ? sw_wdata[3:0] : addr;
      next_wdata  = (sw_wr && sw_addr == `SEA_CREG_WDATA) ? sw_wdata : wdata;
      next_period = (sw_wr && sw_addr == `SEA_CREG_PERIOD) ? sw_wdata[PERIOD_W-1:0] : period;
      next_halt   = halt | link.owner_uncorr;
      if (sw_wr && sw_addr == `SEA_CREG_CMD && sw_wdata[`SEA_CMD_WRITE]) next_halt = 1'b0;
      next_rdat     = (st == SEA_WAIT) ? link.reg_rdata : rdat;
      next_st       = st;
      next_tmr      = tmr;
      next_spur_req = spur_req;
      l_rd = 1'b0;
      l_wr = 1'b0;
      l_addr  = addr;
      l_wdata = wdata;
      if (period != '0) next_tmr = (tmr == '0) ? period : tmr - 1'b1;
      unique case (st)
         SEA_IDLE: begin
            if (sw_wr && sw_addr == `SEA_CREG_CMD) begin
               if (sw_wdata[`SEA_CMD_READ] || sw_wdata[`SEA_CMD_STBY]) next_st = SEA_RD;
               else if (sw_wdata[`SEA_CMD_POLL]) next_st = SEA_RD;
               else if (sw_wdata[`SEA_CMD_CLRSPUR]) begin
                  next_st = SEA_RD;
                  next_spur_req = 1'b1;
               end else if (sw_wdata[`SEA_CMD_WRITE]) l_wr = 1'b1;
            end else if (period != '0 && tmr == '0) begin
               next_st = SEA_RD;
            end
         end
         SEA_RD: begin
            l_rd = 1'b1;
            if (spur_req) l_addr = `SEA_REG_ERROR_INFO;
            next_st = SEA_WAIT;
         end
         SEA_WAIT: next_st = spur_req ? SEA_SPUR : SEA_IDLE;
         SEA_SPUR: begin
            // Clear only when error info reads zero
            if (rdat == `SEA_ZERO32) begin
               l_wr = 1'b1;
               l_addr = `SEA_REG_CLEAR;
               l_wdata = 32'h8000_0007;
            end
            next_spur_req = 1'b0;
            next_st = SEA_IDLE;
         end
      endcase
      next_swr = `SEA_ZERO32;
      if (sw_rd) begin
         unique case (sw_addr)
            `SEA_CREG_STATUS: next_swr = {{(32-`SEA_EV_W){1'b0}}, status};
            `SEA_CREG_ENABLE: next_swr = {{(32-`SEA_EV_W){1'b0}}, enable};
            `SEA_CREG_ADDR:   next_swr = {28'd0, addr};
            `SEA_CREG_WDATA:  next_swr = wdata;
            `SEA_CREG_RDATA:  next_swr = rdat;
            `SEA_CREG_PERIOD: next_swr = 32'(period);
            `SEA_CREG_CMD:    next_swr = {30'd0, halt, st != SEA_IDLE};
            default:          next_swr = `SEA_ZERO32;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st <= SEA_IDLE;
         status <= '0;
         enable <= '0;
         addr <= '0;
         wdata <= '0;
         rdat <= '0;
         swr <= '0;
         period <= '0;
         tmr <= '0;
         halt <= 1'b0;
         spur_req <= 1'b0;
      end else begin
         st <= next_st;
         status <= next_status;
         enable <= next_enable;
         addr <= next_addr;
         wdata <= next_wdata;
         rdat <= next_rdat;
         swr <= next_swr;
         period <= next_period;
         tmr <= next_tmr;
         halt <= next_halt;
         spur_req <= next_spur_req;
      end
   end

   assign link.reg_rd    = l_rd;
   assign link.reg_wr    = l_wr;
   assign link.reg_addr  = l_addr;
   assign link.reg_wdata = l_wdata;
   assign sw_rdata   = swr;
   assign irq        = |(status & enable);
   assign owner_halt = halt;
endmodule

// ===== design/sea_defs.svh
// Constant definitions for the SRAM error alarm reporting block
`ifndef SEA_DEFS_SVH
`define SEA_DEFS_SVH
`define SEA_ADDR_W       4
`define SEA_DATA_W       32
// Device register offsets on the link
`define SEA_REG_ECC_DETECT   4'h0
`define SEA_REG_FAULT_STATUS 4'h1
`define SEA_REG_ERROR_INFO   4'h2
`define SEA_REG_MAP_CTRL     4'h3
`define SEA_REG_CLEAR        4'h4
// Field positions
`define SEA_BIT_CORR     0
`define SEA_BIT_UNCORR   1
`define SEA_BIT_ADDR     2
`define SEA_BIT_OPERR0   0
`define SEA_BIT_SELFTEST 0
`define SEA_BIT_MAPPED   1
// Controller register offsets on the software port
`define SEA_CREG_STATUS  4'h0
`define SEA_CREG_ENABLE  4'h1
`define SEA_CREG_CLEAR   4'h2
`define SEA_CREG_CMD     4'h3
`define SEA_CREG_ADDR    4'h4
`define SEA_CREG_WDATA   4'h5
`define SEA_CREG_RDATA   4'h6
`define SEA_CREG_PERIOD  4'h7
// Controller event bits
`define SEA_EV_ALARM     0
`define SEA_EV_NOTIFY    1
`define SEA_EV_DONE      2
`define SEA_EV_SPURIOUS  3
`define SEA_EV_W         4
// Command bits
`define SEA_CMD_READ     0
`define SEA_CMD_WRITE    1
`define SEA_CMD_POLL     2
`define SEA_CMD_STBY     3
`define SEA_CMD_CLRSPUR  4
`define SEA_INIT_CYCLES  64
`define SEA_ZERO32       32'h0000_0000
`endif

// ===== design/sea_pkg.sv
// Types shared by both ends of the SRAM error alarm link
package sea_pkg;
   typedef logic [3:0]  sea_addr_t;
   typedef logic [31:0] sea_word_t;
   typedef enum logic [1:0] {SEA_ERR_NONE, SEA_ERR_CORR, SEA_ERR_UNCORR,
                             SEA_ERR_ADDR} sea_err_e;
endpackage

// ===== design/sea_link_if.sv
// Link between a memory support instance and its alarm collector / owner
`timescale 1ns/1ps
interface sea_link_if;
   // Register access from the collector side
   logic                 reg_rd;
   logic                 reg_wr;
   sea_pkg::sea_addr_t   reg_addr;
   sea_pkg::sea_word_t   reg_wdata;
   sea_pkg::sea_word_t   reg_rdata;
   // Events toward collector and owner
   logic                 alarm_corr;
   logic                 alarm_uncorr;
   logic                 alarm_addr;
   logic                 owner_notify;
   logic                 owner_uncorr;
   logic                 init_busy;
   modport device (input reg_rd, reg_wr, reg_addr, reg_wdata,
                   output reg_rdata, alarm_corr, alarm_uncorr, alarm_addr,
                          owner_notify, owner_uncorr, init_busy);
   modport collector (output reg_rd, reg_wr, reg_addr, reg_wdata,
                      input reg_rdata, alarm_corr, alarm_uncorr, alarm_addr,
                            owner_notify, owner_uncorr, init_busy);
endinterface

// ===== design/sea_support.sv
// SRAM support instance: error capture, alarms, owner notice, init
`timescale 1ns/1ps
`include "sea_defs.svh"
module sea_support #(
   parameter bit GATED_ALARM   = 1'b0,
   parameter bit SPURIOUS_AR   = 1'b0,
   parameter int INIT_CYCLES   = `SEA_INIT_CYCLES
) (
   // Clock and resets
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              app_reset_seen,
   // SRAM access monitor
   input  wire logic              mem_access,
   input  wire logic              mem_write,
   input  wire logic [31:0]       mem_addr,
   input  wire logic              fault_corr,
   input  wire logic              fault_uncorr,
   input  wire logic              fault_addr,
   input  wire logic              init_abort,
   // Link
   sea_link_if.device             link
);
   import sea_pkg::*;
   initial begin
      if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) $error("INIT_CYCLES out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [2:0]  detect, next_detect;
   logic [2:0]  fstat, next_fstat;
   logic [31:0] info, next_info;
   logic [1:0]  mapctl, next_mapctl;
   logic [2:0]  pend, next_pend;
   logic [15:0] init_cnt, next_init_cnt;
   logic [31:0] rdata, next_rdata;
   logic [2:0]  alarm, next_alarm;
   logic        spur_done, next_spur_done;
   logic [2:0]  ev;
   logic        touch;
   logic        clr_wr;

   always_comb begin
      ev = '0;
      ev[`SEA_BIT_CORR]   = mem_access && !mem_write && fault_corr;
      ev[`SEA_BIT_UNCORR] = mem_access && !mem_write && fault_uncorr;
      ev[`SEA_BIT_ADDR]   = mem_access && fault_addr;
      touch  = mem_access || link.reg_rd || link.reg_wr;
      clr_wr = link.reg_wr && link.reg_addr == `SEA_REG_CLEAR;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status, alarms and init
   always_comb begin
      next_detect    = detect;
      next_fstat     = fstat;
      next_info      = info;
      next_mapctl    = mapctl;
      next_pend      = pend;
      next_init_cnt  = init_cnt;
      next_alarm     = '0;
      next_spur_done = spur_done;
      next_rdata     = `SEA_ZERO32;
      // Clear first so a same-cycle event still sets
      if (clr_wr) begin
         next_detect = detect & ~link.reg_wdata[2:0];
         next_fstat  = fstat & ~link.reg_wdata[2:0];
         if (link.reg_wdata[31]) next_info = `SEA_ZERO32;
      end
      next_detect = next_detect | ev;
      if (ev[`SEA_BIT_UNCORR]) next_fstat[`SEA_BIT_OPERR0] = 1'b1;
      if (|ev) next_info = mem_addr;
      // Spurious post-reset flags with zero error info
      if (SPURIOUS_AR && app_reset_seen && !spur_done) begin
         next_detect[`SEA_BIT_UNCORR] = 1'b1;
         next_fstat[`SEA_BIT_OPERR0]  = 1'b1;
         next_info      = `SEA_ZERO32;
         next_spur_done = 1'b1;
      end
      if (GATED_ALARM) begin
         if (touch) next_alarm = pend;
         next_pend = (touch ? 3'b000 : pend) | ev;
      end else begin
         next_alarm = ev;
      end
      if (link.reg_wr && link.reg_addr == `SEA_REG_MAP_CTRL) begin
         next_mapctl = link.reg_wdata[1:0];
         if (link.reg_wdata[1:0] != mapctl) next_init_cnt = 16'(INIT_CYCLES);
      end else if (init_abort) begin
         next_init_cnt = '0;
      end else if (init_cnt != '0) begin
         next_init_cnt = init_cnt - 16'd1;
      end
      if (link.reg_rd) begin
         unique case (link.reg_addr)
            `SEA_REG_ECC_DETECT:   next_rdata = {29'd0, detect};
            `SEA_REG_FAULT_STATUS: next_rdata = {29'd0, fstat};
            `SEA_REG_ERROR_INFO:   next_rdata = info;
            `SEA_REG_MAP_CTRL:     next_rdata = {30'd0, mapctl};
            default:               next_rdata = `SEA_ZERO32;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         detect    <= '0;
         fstat     <= '0;
         info      <= '0;
         mapctl    <= '0;
         pend      <= '0;
         init_cnt  <= '0;
         alarm     <= '0;
         rdata     <= '0;
         spur_done <= 1'b0;
      end else begin
         detect    <= next_detect;
         fstat     <= next_fstat;
         info      <= next_info;
         mapctl    <= next_mapctl;
         pend      <= next_pend;
         init_cnt  <= next_init_cnt;
         alarm     <= next_alarm;
         rdata     <= next_rdata;
         spur_done <= next_spur_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; owner path is combinational and never gated
   assign link.alarm_corr   = alarm[`SEA_BIT_CORR];
   assign link.alarm_uncorr = alarm[`SEA_BIT_UNCORR];
   assign link.alarm_addr   = alarm[`SEA_BIT_ADDR];
   assign link.owner_notify = |ev;
   assign link.owner_uncorr = ev[`SEA_BIT_UNCORR];
   assign link.init_busy    = init_cnt != '0;
   assign link.reg_rdata    = rdata;
endmodule

// ===== test/sea_link_chk.sv
// Assertions on the link between a memory support instance and its collector
`timescale 1ns/1ps
`include "sea_defs.svh"
module sea_link_chk (
   // Clock and reset
   input wire logic               clock,
   input wire logic               rst_n,
   // Access monitor
   input wire logic               mem_access,
   input wire logic               mem_write,
   input wire logic               fault_corr,
   input wire logic               fault_uncorr,
   input wire logic               fault_addr,
   // Link
   input wire logic               reg_rd,
   input wire logic               reg_wr,
   input wire sea_pkg::sea_addr_t reg_addr,
   input wire sea_pkg::sea_word_t reg_wdata,
   input wire sea_pkg::sea_word_t reg_rdata,
   input wire logic               alarm_corr,
   input wire logic               alarm_uncorr,
   input wire logic               alarm_addr,
   input wire logic               owner_notify,
   input wire logic               owner_uncorr,
   input wire logic               init_busy
);
   import sea_pkg::*;
   ////////////////////////////////////////
   logic       corr_seen;
   logic       next_corr_seen;
   logic [1:0] map_q;
   logic [1:0] next_map_q;
   // Shadow of the correctable bit and of the map control value
   always_comb begin
      next_corr_seen = corr_seen;
      next_map_q = map_q;
      if (reg_wr && reg_addr == `SEA_REG_CLEAR && reg_wdata[`SEA_BIT_CORR])
         next_corr_seen = 1'b0;
      if (mem_access && !mem_write && fault_corr)
         next_corr_seen = 1'b1;
      if (reg_wr && reg_addr == `SEA_REG_MAP_CTRL)
         next_map_q = reg_wdata[1:0];
      if (!rst_n) begin
         next_corr_seen = 1'b0;
         next_map_q = 2'b00;
      end
   end
   always_ff @(posedge clock) begin
      corr_seen <= next_corr_seen;
      map_q <= next_map_q;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_rd_acc;
      mem_access && !mem_write;
   endsequence
   sequence s_map_change;
      reg_wr && reg_addr == `SEA_REG_MAP_CTRL && reg_wdata[1:0] != map_q;
   endsequence
   property p_corr_alarm;
      s_rd_acc ##0 fault_corr |=> alarm_corr;
   endproperty
   a_corr_alarm: assert property (p_corr_alarm) else $error("corr alarm missing");
   property p_uncorr_alarm;
      s_rd_acc ##0 fault_uncorr |=> alarm_uncorr;
   endproperty
   a_uncorr_alarm: assert property (p_uncorr_alarm) else $error("uncorr alarm missing");
   property p_addr_alarm;
      mem_access && fault_addr |=> alarm_addr;
   endproperty
   a_addr_alarm: assert property (p_addr_alarm) else $error("addr alarm missing");
   property p_write_quiet;
      mem_access && mem_write && !fault_addr |=> !alarm_corr && !alarm_addr;
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("alarm on clean write");
   property p_owner_uncorr;
      s_rd_acc ##0 fault_uncorr |-> owner_uncorr && owner_notify;
   endproperty
   a_owner_uncorr: assert property (p_owner_uncorr) else $error("owner not told");
   property p_owner_idle;
      !mem_access |-> !owner_notify;
   endproperty
   a_owner_idle: assert property (p_owner_idle) else $error("owner told without access");
   property p_sticky;
      reg_rd && reg_addr == `SEA_REG_ECC_DETECT && corr_seen |=> reg_rdata[`SEA_BIT_CORR];
   endproperty
   a_sticky: assert property (p_sticky) else $error("detect bit lost");
   property p_rdata_idle;
      !reg_rd |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_init_start;
      s_map_change |=> ##[0:2] init_busy;
   endproperty
   a_init_start: assert property (p_init_start) else $error("init not started");
   property p_init_end;
      $rose(init_busy) |-> ##[1:80] !init_busy;
   endproperty
   a_init_end: assert property (p_init_end) else $error("init too long");
endmodule

// ===== test/test_sram_error_alarm_reporting.sv
// Self-checking bench for the memory support instance and its collector
`timescale 1ns/1ps
`include "sea_defs.svh"
module test_sram_error_alarm_reporting;
   import sea_pkg::*;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        app_reset_seen = 1'b0;
   logic        mem_access = 1'b0;
   logic        mem_write = 1'b0;
   logic [31:0] mem_addr = 32'h0000_0000;
   logic [2:0]  flt = 3'b000;
   logic        init_abort = 1'b0;
   sea_addr_t   sw_addr = 4'h0;
   sea_word_t   sw_wdata = 32'h0000_0000;
   logic        sw_wr = 1'b0;
   logic        sw_rd = 1'b0;
   sea_word_t   sw_rdata;
   sea_word_t   rd;
   logic        irq;
   logic        owner_halt;
   int          bad_count = 0;
   int          n_tests = 0;
   int          i;
   always #2 clock = ~clock;
   sea_link_if i_sea_link_if ();
   sea_support #(.GATED_ALARM(1'b0), .SPURIOUS_AR(1'b1), .INIT_CYCLES(64)) i_sea_support (
      .clock(clock), .rst_n(rst_n), .app_reset_seen(app_reset_seen),
      .mem_access(mem_access), .mem_write(mem_write), .mem_addr(mem_addr),
      .fault_corr(flt[0]), .fault_uncorr(flt[1]), .fault_addr(flt[2]),
      .init_abort(init_abort), .link(i_sea_link_if.device));
   sea_collector #(.PERIOD_W(16)) i_sea_collector (
      .clock(clock), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq),
      .owner_halt(owner_halt), .link(i_sea_link_if.collector));
   sea_link_chk i_sea_link_chk (
      .clock(clock), .rst_n(rst_n), .mem_access(mem_access), .mem_write(mem_write),
      .fault_corr(flt[0]), .fault_uncorr(flt[1]), .fault_addr(flt[2]),
      .reg_rd(i_sea_link_if.reg_rd), .reg_wr(i_sea_link_if.reg_wr),
      .reg_addr(i_sea_link_if.reg_addr), .reg_wdata(i_sea_link_if.reg_wdata),
      .reg_rdata(i_sea_link_if.reg_rdata), .alarm_corr(i_sea_link_if.alarm_corr),
      .alarm_uncorr(i_sea_link_if.alarm_uncorr), .alarm_addr(i_sea_link_if.alarm_addr),
      .owner_notify(i_sea_link_if.owner_notify), .owner_uncorr(i_sea_link_if.owner_uncorr),
      .init_busy(i_sea_link_if.init_busy));
   ////////////////////////////////////////
   task automatic chk(input string what, input sea_word_t exp, input sea_word_t got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      if (bad_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic sw_write(input sea_addr_t a, input sea_word_t d);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clock);
      sw_wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic sw_read(input sea_addr_t a, output sea_word_t d);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clock);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
      @(posedge clock);
   endtask
   // Device register access through the collector's command engine
   task automatic link_op(input sea_addr_t a, input sea_word_t wd, input int cmd,
                          output sea_word_t d);
      int k;
      sw_write(`SEA_CREG_ADDR, {28'h000_0000, a});
      sw_write(`SEA_CREG_WDATA, wd);
      sw_write(`SEA_CREG_CMD, 32'h0000_0001 << cmd);
      d = 32'h0000_0001;
      for (k = 0; k < 200 && d[0] !== 1'b0; k++)
         sw_read(`SEA_CREG_CMD, d);
      if (d[0] !== 1'b0) begin
         bad_count++;
         complete_run();
      end
      sw_write(`SEA_CREG_CLEAR, 32'h0000_000F);
      sw_read(`SEA_CREG_RDATA, d);
   endtask
   task automatic acc(input logic w, input logic [2:0] f);
      mem_access <= 1'b1;
      mem_write <= w;
      mem_addr <= mem_addr + 32'h0000_0004;
      flt <= f;
      @(posedge clock);
      mem_access <= 1'b0;
      flt <= 3'b000;
      @(posedge clock);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (50000) @(posedge clock);
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      link_op(`SEA_REG_ECC_DETECT, 32'h0000_0000, `SEA_CMD_READ, rd);
      chk("detect after reset", 32'h0000_0000, rd);
      link_op(`SEA_REG_FAULT_STATUS, 32'h0000_0000, `SEA_CMD_READ, rd);
      chk("fault status after reset", 32'h0000_0000, rd);
      sw_write(`SEA_CREG_ENABLE, 32'h0000_0001);
      acc(1'b0, 3'b001);
      // Alarm is registered once, then latched in the status register
      @(posedge clock);
      chk("irq on alarm", 32'h0000_0001, {31'h0, irq});
      acc(1'b0, 3'b010);
      chk("owner halt", 32'h0000_0001, {31'h0, owner_halt});
      acc(1'b1, 3'b100);
      repeat (20) @(posedge clock);
      link_op(`SEA_REG_ECC_DETECT, 32'h0000_0000, `SEA_CMD_READ, rd);
      chk("detect bits", 32'h0000_0007, rd);
      link_op(`SEA_REG_FAULT_STATUS, 32'h0000_0000, `SEA_CMD_READ, rd);
      chk("fault status", 32'h0000_0001, rd);
      sw_write(`SEA_CREG_ENABLE, 32'h0000_0000);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      sw_read(4'hF, rd);
      chk("unmapped read", 32'h0000_0000, rd);
      link_op(`SEA_REG_CLEAR, 32'h8000_0007, `SEA_CMD_WRITE, rd);
      chk("halt released", 32'h0000_0000, {31'h0, owner_halt});
      link_op(`SEA_REG_ECC_DETECT, 32'h0000_0000, `SEA_CMD_READ, rd);
      chk("detect cleared", 32'h0000_0000, rd);
      link_op(`SEA_REG_MAP_CTRL, 32'h0000_0002, `SEA_CMD_WRITE, rd);
      chk("init running", 32'h0000_0001, {31'h0, i_sea_link_if.init_busy});
      init_abort <= 1'b1;
      @(posedge clock);
      init_abort <= 1'b0;
      for (i = 0; i < 4 && i_sea_link_if.init_busy !== 1'b0; i++)
         @(posedge clock);
      chk("init aborted", 32'h0000_0000, {31'h0, i_sea_link_if.init_busy});
      link_op(`SEA_REG_MAP_CTRL, 32'h0000_0003, `SEA_CMD_WRITE, rd);
      for (i = 0; i < 100 && i_sea_link_if.init_busy !== 1'b0; i++)
         @(posedge clock);
      chk("init finished", 32'h0000_0000, {31'h0, i_sea_link_if.init_busy});
      link_op(`SEA_REG_ECC_DETECT, 32'h0000_0000, `SEA_CMD_STBY, rd);
      chk("standby dummy read", 32'h0000_0000, rd);
      sw_write(`SEA_CREG_PERIOD, 32'h0000_0010);
      repeat (40) @(posedge clock);
      sw_write(`SEA_CREG_PERIOD, 32'h0000_0000);
      repeat (4) @(posedge clock);
      sw_read(`SEA_CREG_STATUS, rd);
      chk("periodic poll done", 32'h0000_0004, rd & 32'h0000_0004);
      sw_write(`SEA_CREG_CLEAR, 32'h0000_000F);
      app_reset_seen <= 1'b1;
      rst_n <= 1'b0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      link_op(`SEA_REG_FAULT_STATUS, 32'h0000_0000, `SEA_CMD_READ, rd);
      chk("spurious error bit", 32'h0000_0001, rd);
      link_op(`SEA_REG_ERROR_INFO, 32'h0000_0000, `SEA_CMD_READ, rd);
      chk("spurious info", 32'h0000_0000, rd);
      link_op(4'h0, 32'h0000_0000, `SEA_CMD_CLRSPUR, rd);
      link_op(`SEA_REG_FAULT_STATUS, 32'h0000_0000, `SEA_CMD_READ, rd);
      chk("spurious cleared", 32'h0000_0000, rd);
      complete_run();
   end
endmodule
